// ==== dacrs_pkg.sv ====
// How it works
// RULE1: Each channel has an overrange enable bit that widens only voltage ranges, never current ranges, and resets to disabled.
// RULE2: The three-bit range select decodes 000 0-5 V (reset), 001 0-10 V, 010 +-5 V, 011 +-10 V, 100 4-20 mA, 101 0-20 mA, 110 0-24 mA.
// RULE3: Issuing the reset function through the software register resets the whole part.
// RULE4: Bit D12 of a software register write sets or clears the user toggle bit seen at status position D11.
// RULE5: With the watchdog on, the host writes 0x195 to the software register before each timeout ends.
// RULE6: With the watchdog on and no code within the timeout, the alert output signals a fault.
// RULE7: With the watchdog off, no code writes are needed and no watchdog fault is raised.
// RULE8: A write whose top three bits are 100 selects the software register; D12 is the toggle value and D11 to D0 the function code.
// RULE9: Writing 0x555 into the function-code bits performs the software reset.
// RULE10: Every accepted watchdog code write restarts the timeout count.
package dacrs_pkg;
	localparam int NUM_CH = 4;
	localparam logic [2:0] SW_REG_SEL = 3'h4;
	localparam int SEL_MSB = 15;
	localparam int SEL_LSB = 13;
	localparam int TOGGLE_POS = 12;
	localparam int CODE_MSB = 11;
	localparam logic [11:0] RESET_CODE = 12'h555;
	localparam logic [11:0] WDOG_CODE = 12'h195;
	localparam int STATUS_TOGGLE_POS = 11;
	localparam logic [2:0] RANGE_RESET = 3'h0;
	localparam logic OVR_RESET = 1'b0;
	localparam int CLK_HZ = 20000000;
	localparam int WDOG_TIMEOUT_US = 1000;
	localparam int WDOG_CYCLES = WDOG_TIMEOUT_US * (CLK_HZ / 1000000);

	typedef enum logic [2:0] {
		DACRS_R_0_5V,
		DACRS_R_0_10V,
		DACRS_R_PM5V,
		DACRS_R_PM10V,
		DACRS_R_4_20MA,
		DACRS_R_0_20MA,
		DACRS_R_0_24MA,
		DACRS_R_BAD
	} dacrs_range_t;

	typedef struct packed {
		logic is_voltage;
		logic is_current;
		logic is_bipolar;
		logic overrange;
		logic valid;
	} dacrs_chan_t;
endpackage

// ==== dacrs_chan_decode.sv ====
`timescale 1ns/10ps
module dacrs_chan_decode
	import dacrs_pkg::*;
(
	input wire logic [2:0] output_range_select, // Range field.
	input wire logic voltage_overrange_enable, // Overrange request.
	output dacrs_chan_t info // Decoded channel mode.
);
	always_comb
	begin
		info = '0;
		info.valid = 1'b1;
		unique case (output_range_select)
			3'h0, 3'h1:
			begin
				info.is_voltage = 1'b1; // see RULE2
			end
			3'h2, 3'h3:
			begin
				info.is_voltage = 1'b1;
				info.is_bipolar = 1'b1; // see RULE2
			end
			3'h4, 3'h5, 3'h6:
			begin
				info.is_current = 1'b1; // see RULE2
			end
			default:
			begin
				info.valid = 1'b0;
			end
		endcase
		// Current ranges never take the overrange.
		info.overrange = info.is_voltage & voltage_overrange_enable; // see RULE1
	end
endmodule // dacrs_chan_decode

// ==== dacrs_top.sv ====
`timescale 1ns/10ps
module dacrs_top
	import dacrs_pkg::*;
#(
	parameter int WDOG_COUNT = WDOG_CYCLES
)
(
	input wire logic clk, // 20 MHz clock.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic wr_valid, // One-cycle strobe of a received frame.
	input wire logic [15:0] wr_data, // Frame data bits D15 to D0.
	input wire logic ctrl_wr, // Control register write strobe.
	input wire logic [1:0] ctrl_ch, // Channel of the control write.
	input wire logic [2:0] ctrl_range, // New output_range_select.
	input wire logic ctrl_ovr, // New voltage_overrange_enable.
	input wire logic wdog_enable, // Watchdog on.
	output logic [11:0] output_range_select, // Ranges, three bits a channel.
	output logic [3:0] overrange_active, // Effective overrange per channel.
	output logic [3:0] current_mode, // Channel in a current range.
	output logic [15:0] status, // Status word, toggle at D11.
	output logic soft_reset, // Pulse on software reset.
	output logic alert // Watchdog fault, level.
);
	logic [2:0] range_q [NUM_CH];
	logic [NUM_CH-1:0] ovr_q;
	logic toggle;
	logic [31:0] wd_cnt;
	logic sw_sel;
	logic do_reset;
	logic wd_kick;
	dacrs_chan_t info [NUM_CH];

	// ------------------------------------------------------------
	// Software register decode
	// ------------------------------------------------------------
	assign sw_sel = wr_valid && wr_data[SEL_MSB:SEL_LSB] == SW_REG_SEL; // see RULE8
	assign do_reset = sw_sel && wr_data[CODE_MSB:0] == RESET_CODE; // see RULE9
	assign wd_kick = sw_sel && wr_data[CODE_MSB:0] == WDOG_CODE; // see RULE5

	always_ff @(posedge clk)
	begin
		if (!rstn)
			soft_reset <= 1'b0;
		else
			soft_reset <= do_reset; // see RULE3
	end

	// ------------------------------------------------------------
	// Per-channel range and overrange
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			always_ff @(posedge clk)
			begin
				if (!rstn || do_reset)
				begin
					range_q[g] <= RANGE_RESET; // see RULE2
					ovr_q[g] <= OVR_RESET; // see RULE1
				end
				else if (ctrl_wr && ctrl_ch == 2'(g))
				begin
					range_q[g] <= ctrl_range;
					ovr_q[g] <= ctrl_ovr;
				end
			end

			dacrs_chan_decode u_dec (
				.output_range_select(range_q[g]),
				.voltage_overrange_enable(ovr_q[g]),
				.info(info[g])
			);

			always_ff @(posedge clk)
			begin
				if (!rstn)
				begin
					output_range_select[3*g +: 3] <= RANGE_RESET;
					overrange_active[g] <= 1'b0;
					current_mode[g] <= 1'b0;
				end
				else
				begin
					output_range_select[3*g +: 3] <= range_q[g];
					overrange_active[g] <= info[g].overrange; // see RULE1
					current_mode[g] <= info[g].is_current;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// User toggle bit and status
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn || do_reset)
			toggle <= 1'b0;
		else if (sw_sel && !do_reset)
			toggle <= wr_data[TOGGLE_POS]; // see RULE4
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			status <= 16'h0000;
		else
		begin
			status <= 16'h0000;
			status[STATUS_TOGGLE_POS] <= toggle; // see RULE4
			status[0] <= alert;
		end
	end

	// ------------------------------------------------------------
	// Interface watchdog
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn || do_reset || !wdog_enable || wd_kick)
			wd_cnt <= 32'h0; // see RULE10
		else if (wd_cnt < 32'(WDOG_COUNT))
			wd_cnt <= wd_cnt + 32'h1;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn || do_reset || !wdog_enable)
			alert <= 1'b0; // see RULE7
		else if (wd_kick)
			alert <= 1'b0;
		else if (wd_cnt >= 32'(WDOG_COUNT) - 32'h1)
			alert <= 1'b1; // see RULE6
	end
endmodule // dacrs_top

// ==== dacrs_host.sv ====
`timescale 1ns/10ps
module dacrs_host
	import dacrs_pkg::*;
(
	input wire logic clk, // Clock.
	output logic wr_valid = 1'b0, // Frame strobe.
	output logic [15:0] wr_data = 16'h0 // Frame bits.
);
	// A released data line shows the inverse of the last frame.
	task automatic send(input logic [15:0] d);
		@(negedge clk) {wr_valid, wr_data} = {1'b1, d};
		@(negedge clk) {wr_valid, wr_data} = {1'b0, ~d};
	endtask
	task automatic kick(input logic t);
		send({SW_REG_SEL, t, WDOG_CODE});
	endtask
endmodule // dacrs_host

// ==== dacrs_top_chk.sv ====
`timescale 1ns/10ps
module dacrs_top_chk
	import dacrs_pkg::*;
#(
	parameter int WDOG_COUNT = 20
)
(
	input wire logic clk, rstn, wr_valid, ctrl_wr, ctrl_ovr, wdog_enable, // In.
	input wire logic [15:0] wr_data, status, // Frame, status.
	input wire logic [1:0] ctrl_ch, // Channel.
	input wire logic [2:0] ctrl_range, // Range.
	input wire logic [11:0] output_range_select, // Ranges.
	input wire logic [3:0] overrange_active, current_mode, // Modes.
	input wire logic soft_reset, alert // Events.
);
	int cnt;
	wire sw = wr_valid && wr_data[15:13] == SW_REG_SEL;
	wire rstwr = sw && wr_data[11:0] == RESET_CODE;
	wire kick = sw && wr_data[11:0] == WDOG_CODE;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk)
		cnt <= (!rstn || !wdog_enable || kick || rstwr) ? 0 : cnt + 1;
	a_soft_pulse: assert property (rstwr |=> soft_reset)
		else $error("no reset pulse");
	a_toggle_echo: assert property (sw && !rstwr ##1 !wr_valid
		|=> status[11] == $past(wr_data[12], 2)) else $error("toggle");
	a_ovr_current: assert property (!(|(current_mode & overrange_active)))
		else $error("current overrange");
	a_range_store: assert property (ctrl_wr && !wr_valid ##1 !ctrl_wr
		|=> output_range_select[$past(ctrl_ch, 2) * 3 +: 3]
		== $past(ctrl_range, 2)) else $error("range");
	a_reset_clear: assert property (rstwr && !ctrl_wr ##1 !ctrl_wr
		|=> output_range_select == 12'h0 && overrange_active == 4'h0)
		else $error("reset left state");
	a_alert_cause: assert property ($rose(alert) |->
		$past(wdog_enable) && cnt >= WDOG_COUNT - 2) else $error("early alert");
	a_alert_due: assert property (cnt == WDOG_COUNT + 2 |-> alert)
		else $error("no alert");
	a_kick_clear: assert property (kick |-> ##[1:2] !alert)
		else $error("kick kept alert");
	c_timeout: cover property ($rose(alert));
	c_soft: cover property (soft_reset);
	c_kick: cover property (kick ##1 !alert);
endmodule // dacrs_top_chk
bind dacrs_top dacrs_top_chk #(.WDOG_COUNT(WDOG_COUNT)) dacrs_top_chk_inst (.clk,
	.rstn, .wr_valid, .wr_data, .ctrl_wr, .ctrl_ch, .ctrl_range, .ctrl_ovr,
	.wdog_enable, .output_range_select, .overrange_active, .current_mode,
	.status, .soft_reset, .alert);

// ==== dacrs_top_test.sv ====
`timescale 1ns/10ps
module dacrs_top_test;
	localparam int W = 20;
	logic clk = 1'b0, rstn = 1'b0, ctrl_wr = 1'b0, ctrl_ovr = 1'b1;
	logic wdog_enable = 1'b0, wr_valid, soft_reset, alert, seen;
	logic [1:0] ctrl_ch = 2'h0;
	logic [2:0] ctrl_range = 3'h0;
	logic [15:0] wr_data, status;
	logic [11:0] output_range_select;
	logic [3:0] overrange_active, current_mode;
	int errors = 0, n_compared = 0;
	initial forever #25 clk = ~clk;
	dacrs_host dacrs_host_inst (.clk, .wr_valid, .wr_data);
	dacrs_top #(.WDOG_COUNT(W)) dacrs_top_inst (.clk, .rstn, .wr_valid, .wr_data,
		.ctrl_wr, .ctrl_ch, .ctrl_range, .ctrl_ovr, .wdog_enable, .status,
		.output_range_select, .overrange_active, .current_mode, .soft_reset, .alert);
	task automatic chk(input logic [39:0] s, input logic [39:0] e);
		n_compared++;
		errors += (s !== e);
		if (s !== e)
			$display("MISMATCH %0t saw %h want %h", $time, s, e);
	endtask
	task complete_run;
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#100000 errors++;
		complete_run();
	end
	initial
	begin
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		chk({status, output_range_select}, 40'h0);
		for (int r = 0; r < 7; r++)
		begin
			@(negedge clk) {ctrl_wr, ctrl_ch, ctrl_range} = {1'b1, 2'(r % 4), 3'(r)};
			ctrl_ovr = (r != 1);
			@(negedge clk) ctrl_wr = 1'b0;
			@(negedge clk);
			chk({current_mode[r % 4], overrange_active[r % 4],
				output_range_select[r % 4 * 3 +: 3]},
				{r > 3, r < 4 && r != 1, 3'(r)});
		end
		dacrs_host_inst.send(16'h9000);
		repeat (2) @(negedge clk);
		chk(status[11], 1'b1);
		dacrs_host_inst.send(16'h0555);
		repeat (2) @(negedge clk);
		chk({status[11], output_range_select}, {1'b1, 12'h7ac});
		dacrs_host_inst.send(16'h8000);
		repeat (2) @(negedge clk);
		chk(status[11], 1'b0);
		wdog_enable = 1'b1;
		repeat (3)
		begin
			repeat (W - 6) @(negedge clk);
			dacrs_host_inst.kick(1'b1);
		end
		chk(alert, 1'b0);
		repeat (W + 4) @(negedge clk);
		chk(alert, 1'b1);
		dacrs_host_inst.kick(1'b1);
		wdog_enable = 1'b0;
		repeat (W + 4) @(negedge clk);
		chk(alert, 1'b0);
		dacrs_host_inst.send(16'h9555);
		seen = soft_reset;
		@(negedge clk) seen = seen | soft_reset;
		@(negedge clk);
		chk({seen, overrange_active, output_range_select, status},
			{1'b1, 32'h0});
		complete_run();
	end
endmodule // dacrs_top_test
